/* core/dmal_pkg.sv */
package dmal_pkg;
  // ==========================================================
  // bus and storage sizes
  localparam int DW = 32;
  localparam int NDESC = 2;
  localparam int DESC_WORDS = 6;
  // ==========================================================
  // register byte offsets
  localparam logic [31:0] OFS_CTRL = 32'h00;
  localparam logic [31:0] OFS_STAT = 32'h04;
  localparam logic [31:0] OFS_MASK = 32'h08;
  localparam logic [31:0] OFS_INFO = 32'h0c;
  // descriptor block select in addr[6:5], word in addr[4:2]
  localparam logic [1:0] DSEL_0 = 2'h1;
  localparam logic [1:0] DSEL_1 = 2'h2;
  localparam logic [2:0] W_SRC = 3'h0;
  localparam logic [2:0] W_DST = 3'h1;
  localparam logic [2:0] W_CNT = 3'h2;
  localparam logic [2:0] W_XINC = 3'h3;
  localparam logic [2:0] W_YINC = 3'h4;
  localparam logic [2:0] W_CFG = 3'h5;
  // ==========================================================
  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_CHAIN = 1;
  localparam int CTRL_SWTRIG = 2;
  localparam int CFG_SW = 0;
  localparam int CFG_DW = 2;
  localparam int CFG_TMODE = 4;
  localparam int CFG_IRQ_ELEM = 5;
  localparam int CFG_TOUT_ELEM = 6;
  localparam int ST_DESC = 0;
  localparam int ST_CHAN = 1;
  // ==========================================================
  // encodings and reset values
  localparam logic [1:0] WID_8 = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h2;
  localparam logic TM_ELEM = 1'h0;
  localparam logic TM_XLOOP = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RST_MASK = 2'h0;
  typedef logic [DESC_WORDS-1:0][31:0] dmal_desc_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_RD = 3'h3,
    ST_WR = 3'h2,
    ST_STEP = 3'h6
  } dmal_state_e;
endpackage

/* core/dmal_reg_if.sv */
`timescale 1ns/1ps
interface dmal_reg_if;
  logic wr;
  logic [31:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_err;
  logic rd;
  logic [31:0] raddr;
  logic [31:0] rdata;
  logic rd_err;
  // bus side issues accesses, register side answers
  modport bus (output wr, waddr, wdata, wstrb, rd, raddr,
               input wr_err, rdata, rd_err);
  modport regs (input wr, waddr, wdata, wstrb, rd, raddr,
                output wr_err, rdata, rd_err);
endinterface

/* core/dmal_axil.sv */
`timescale 1ns/1ps
module dmal_axil
  import dmal_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register access
  dmal_reg_if.bus rg
);
  typedef struct packed {
    logic aw_have;
    logic [31:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_rdy;
    logic w_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dmal_axil_s;
  dmal_axil_s s_r;
  dmal_axil_s s_nxt;
  logic do_wr;
  logic do_rd;

  // ==========================================================
  // address and data are taken in either order, response after both
  always_comb begin
    s_nxt = s_r;
    do_wr = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    do_rd = arvalid && s_r.ar_rdy;
    if (awvalid && s_r.aw_rdy) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && s_r.w_rdy) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (do_wr) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = rg.wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    s_nxt.aw_rdy = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.w_rdy = !s_nxt.w_have && !s_nxt.bvalid;
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (do_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rg.rdata;
      s_nxt.rresp = rg.rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    s_nxt.ar_rdy = !s_nxt.rvalid;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // register access strobes and slave outputs
  assign rg.wr = do_wr;
  assign rg.waddr = s_r.aw_addr;
  assign rg.wdata = s_r.w_data;
  assign rg.wstrb = s_r.w_strb;
  assign rg.rd = do_rd;
  assign rg.raddr = araddr;
  assign awready = s_r.aw_rdy;
  assign wready = s_r.w_rdy;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.ar_rdy;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
endmodule

/* core/dmal_wconv.sv */
`timescale 1ns/1ps
module dmal_wconv
  import dmal_pkg::*;
(
  // element data and lane positions
  input wire logic [31:0] raw,
  input wire logic [1:0] sa,
  input wire logic [1:0] sw,
  input wire logic [1:0] da,
  input wire logic [1:0] dw,
  // destination lanes
  output logic [31:0] wdata,
  output logic [3:0] be
);
  // ==========================================================
  // source lane align, then keep only the low destination bits
  always_comb begin
    logic [31:0] v;
    v = raw >> {sa, 3'h0};
    if (sw == WID_8) begin
      v = {24'h0, v[7:0]};
    end else if (sw == WID_16) begin
      v = {16'h0, v[15:0]};
    end
    case (dw)
      WID_8: begin
        wdata = {4{v[7:0]}}; // R11
        be = 4'h1 << da;
      end
      WID_16: begin
        wdata = {2{v[15:0]}}; // R10
        be = 4'h3 << {da[1], 1'h0};
      end
      default: begin
        wdata = v;
        be = 4'hf;
      end
    endcase
  end
endmodule

/* core/dmal_top.sv */
// Summary of operation
// R1: source and destination advance independently per element; zero holds fixed.
// R2: one X loop moves exactly the configured element count.
// R3: increments above one skip elements, interleaving the writes.
// R4: every X and Y increment is scaled by that side's width.
// R5: end of X loop re-bases both addresses from loop start plus Y increment.
// R6: nonzero Y source increment offsets each next X loop start.
// R7: X loop repeats the configured Y count.
// R8: element trigger mode moves one element per trigger.
// R9: X loop trigger mode runs a whole X loop per trigger.
// R10: word source to halfword destination in one element.
// R11: narrower destination keeps low source bits only.
// R12: completion interrupt once the descriptor finishes.
// R13: interrupt and trigger out each per element or per descriptor.
// R14: trigger output pulses so another channel can be started.
// R15: channel owns two descriptors, processed in turn.
// R16: byte step is increment times element size, modulo address width.
`timescale 1ns/1ps
module dmal_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // axi4-lite register slave
  input wire logic [dmal_pkg::DW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [dmal_pkg::DW-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [dmal_pkg::DW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [dmal_pkg::DW-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // triggers and interrupt
  input wire logic TRIG_IN,
  output logic TRIG_OUT,
  output logic IRQ,
  // system bus master
  output logic BUS_REQ,
  output logic BUS_WE,
  output logic [dmal_pkg::DW-1:0] BUS_ADDR,
  output logic [1:0] BUS_SIZE,
  output logic [dmal_pkg::DW-1:0] BUS_WDATA,
  output logic [3:0] BUS_BE,
  input wire logic BUS_ACK,
  input wire logic [dmal_pkg::DW-1:0] BUS_RDATA
);
  import dmal_pkg::*;

  typedef struct packed {
    dmal_state_e st;
    logic en;
    logic chain;
    logic cur;
    logic pend;
    logic inx;
    logic [1:0] stat;
    logic [1:0] mask;
    dmal_desc_t [NDESC-1:0] d;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] xsrc;
    logic [31:0] xdst;
    logic [15:0] xi;
    logic [15:0] yi;
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic tout;
    logic irq;
  } dmal_main_s;

  dmal_main_s s_r;
  dmal_main_s s_nxt;
  dmal_reg_if rg ();
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_err;
  logic [31:0] cv_wdata;
  logic [3:0] cv_be;
  dmal_desc_t cd;
  logic [1:0] sw;
  logic [1:0] dw;
  logic tmode;
  logic [15:0] xcnt;
  logic [15:0] ycnt;
  logic [31:0] xs_step;
  logic [31:0] xd_step;
  logic [31:0] ys_step;
  logic [31:0] yd_step;
  logic last_x;
  logic last_y;

  // ==========================================================
  // helpers
  // signed increment times element size, wraps at 32 bits
  function automatic logic [31:0] scale(input logic [15:0] inc,
                                        input logic [1:0] w);
    scale = {{16{inc[15]}}, inc} << w; // R16
  endfunction

  // byte lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // descriptor word decode
  function automatic logic dhit(input logic [31:0] a);
    dhit = (a[31:7] == 25'h0) && (a[1:0] == 2'h0) &&
           (a[6:5] == DSEL_0 || a[6:5] == DSEL_1) && (a[4:2] <= W_CFG);
  endfunction

  // ==========================================================
  // register bus slave and element width converter
  dmal_axil u_axil (
    .clk(CLK),
    .rst_n(RESETN),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rg(rg.bus)
  );

  dmal_wconv u_wconv (
    .raw(BUS_RDATA),
    .sa(s_r.src[1:0]),
    .sw(sw),
    .da(s_r.dst[1:0]),
    .dw(dw),
    .wdata(cv_wdata),
    .be(cv_be)
  );

  // ==========================================================
  // active descriptor fields and scaled steps
  assign cd = s_r.d[s_r.cur]; // R15
  assign sw = cd[W_CFG][CFG_SW +: 2];
  assign dw = cd[W_CFG][CFG_DW +: 2];
  assign tmode = cd[W_CFG][CFG_TMODE];
  assign xcnt = cd[W_CNT][15:0];
  assign ycnt = cd[W_CNT][31:16];
  assign xs_step = scale(cd[W_XINC][15:0], sw); // R4 R3
  assign xd_step = scale(cd[W_XINC][31:16], dw); // R4 R3
  assign ys_step = scale(cd[W_YINC][15:0], sw); // R4
  assign yd_step = scale(cd[W_YINC][31:16], dw); // R4
  assign last_x = (s_r.xi + 16'h1) >= xcnt; // R2
  assign last_y = (s_r.yi + 16'h1) >= ycnt; // R7
  assign rg.rdata = rd_data;
  assign rg.rd_err = rd_err;
  assign rg.wr_err = wr_err;

  // ==========================================================
  // registers, sequencer and events
  always_comb begin
    logic [1:0] set;
    logic [1:0] clr;
    logic nd;
    set = 2'h0;
    clr = 2'h0;
    nd = 1'b0;
    s_nxt = s_r;
    s_nxt.tout = 1'b0;
    s_nxt.pend = s_r.pend | TRIG_IN;
    wr_err = 1'b0;
    rd_err = 1'b0;
    rd_data = 32'h0;
    // register read data
    if (rg.raddr == OFS_CTRL) begin
      rd_data = {29'h0, s_r.pend, s_r.chain, s_r.en};
    end else if (rg.raddr == OFS_STAT) begin
      rd_data = {30'h0, s_r.stat};
    end else if (rg.raddr == OFS_MASK) begin
      rd_data = {30'h0, s_r.mask};
    end else if (rg.raddr == OFS_INFO) begin
      rd_data = {s_r.xi, s_r.yi[11:0], s_r.cur, s_r.st};
    end else if (dhit(rg.raddr)) begin
      rd_data = s_r.d[rg.raddr[6]][rg.raddr[4:2]];
    end else begin
      rd_err = 1'b1;
    end
    // register writes
    if (rg.wr) begin
      if (rg.waddr == OFS_CTRL) begin
        if (rg.wstrb[0]) begin
          s_nxt.en = rg.wdata[CTRL_EN];
          s_nxt.chain = rg.wdata[CTRL_CHAIN];
          s_nxt.pend = s_nxt.pend | rg.wdata[CTRL_SWTRIG];
        end
      end else if (rg.waddr == OFS_STAT) begin
        clr = rg.wstrb[0] ? rg.wdata[1:0] : 2'h0;
      end else if (rg.waddr == OFS_MASK) begin
        if (rg.wstrb[0]) begin
          s_nxt.mask = rg.wdata[1:0];
        end
      end else if (dhit(rg.waddr)) begin
        s_nxt.d[rg.waddr[6]][rg.waddr[4:2]] =
          merge(s_r.d[rg.waddr[6]][rg.waddr[4:2]], rg.wdata, rg.wstrb);
      end else begin
        wr_err = 1'b1;
      end
    end
    // transfer sequencer
    case (s_r.st)
      ST_IDLE: begin
        if (s_r.en) begin
          s_nxt.cur = 1'b0;
          nd = 1'b1;
        end
      end
      ST_WAIT: begin
        if (!s_r.en) begin
          s_nxt.st = ST_IDLE;
          s_nxt.inx = 1'b0;
        end else if (s_r.pend || s_r.inx) begin
          if (!s_r.inx) begin
            s_nxt.pend = TRIG_IN; // R8 R9
            s_nxt.inx = (tmode == TM_XLOOP); // R9
          end
          s_nxt.st = ST_RD;
          s_nxt.req = 1'b1;
          s_nxt.we = 1'b0;
          s_nxt.addr = s_r.src;
          s_nxt.size = sw;
          s_nxt.be = 4'hf;
        end
      end
      ST_RD: begin
        if (BUS_ACK) begin
          s_nxt.st = ST_WR;
          s_nxt.we = 1'b1;
          s_nxt.addr = s_r.dst;
          s_nxt.size = dw;
          s_nxt.wdata = cv_wdata; // R10 R11
          s_nxt.be = cv_be;
        end
      end
      ST_WR: begin
        if (BUS_ACK) begin
          s_nxt.st = ST_STEP;
          s_nxt.req = 1'b0;
          s_nxt.we = 1'b0;
        end
      end
      ST_STEP: begin
        s_nxt.st = ST_WAIT;
        set[ST_DESC] = cd[W_CFG][CFG_IRQ_ELEM]; // R13
        s_nxt.tout = cd[W_CFG][CFG_TOUT_ELEM]; // R13 R14
        if (!last_x) begin
          s_nxt.xi = s_r.xi + 16'h1; // R2
          s_nxt.src = s_r.src + xs_step; // R1
          s_nxt.dst = s_r.dst + xd_step; // R1
        end else begin
          s_nxt.inx = 1'b0;
          if (!last_y) begin
            s_nxt.xi = 16'h0;
            s_nxt.yi = s_r.yi + 16'h1; // R7
            s_nxt.xsrc = s_r.xsrc + ys_step; // R5 R6
            s_nxt.xdst = s_r.xdst + yd_step; // R5
            s_nxt.src = s_r.xsrc + ys_step; // R5 R6
            s_nxt.dst = s_r.xdst + yd_step; // R5
          end else begin
            set[ST_DESC] = 1'b1; // R12
            s_nxt.tout = 1'b1; // R14
            if (s_r.chain && !s_r.cur) begin
              s_nxt.cur = 1'b1; // R15
              nd = 1'b1;
            end else begin
              set[ST_CHAN] = 1'b1;
              s_nxt.en = 1'b0;
              s_nxt.st = ST_IDLE;
            end
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // load the next descriptor's start addresses
    if (nd) begin
      s_nxt.src = s_r.d[s_nxt.cur][W_SRC];
      s_nxt.dst = s_r.d[s_nxt.cur][W_DST];
      s_nxt.xsrc = s_r.d[s_nxt.cur][W_SRC];
      s_nxt.xdst = s_r.d[s_nxt.cur][W_DST];
      s_nxt.xi = 16'h0;
      s_nxt.yi = 16'h0;
      s_nxt.st = ST_WAIT;
    end
    // sticky status, set wins over write-one-to-clear
    s_nxt.stat = (s_r.stat & ~clr) | set;
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask); // R12
  end

  // state register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_r <= '0;
      s_r.mask <= RST_MASK;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign TRIG_OUT = s_r.tout;
  assign IRQ = s_r.irq;
  assign BUS_REQ = s_r.req;
  assign BUS_WE = s_r.we;
  assign BUS_ADDR = s_r.addr;
  assign BUS_SIZE = s_r.size;
  assign BUS_WDATA = s_r.wdata;
  assign BUS_BE = s_r.be;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence step_mid_s;
    s_r.st == ST_STEP && !last_x;
  endsequence
  sequence step_ybound_s;
    s_r.st == ST_STEP && last_x && !last_y;
  endsequence

  src_step_a: assert property (step_mid_s |=> // R1
    s_r.src == $past(s_r.src) + $past(xs_step))
    else $error("source did not advance by its step");
  src_fixed_a: assert property ( // R1
    (step_mid_s and cd[W_XINC][15:0] == 16'h0) |=>
    s_r.src == $past(s_r.src)) else $error("zero increment moved");
  x_count_a: assert property (s_r.st == ST_RD |-> // R2
    (s_r.xi < xcnt || xcnt == 16'h0)) else $error("x count overrun");
  y_count_a: assert property (s_r.st == ST_RD |-> // R7
    (s_r.yi < ycnt || ycnt == 16'h0)) else $error("y count overrun");
  y_rebase_a: assert property (step_ybound_s |=> // R5
    s_r.src == $past(s_r.xsrc) + $past(ys_step) &&
    s_r.dst == $past(s_r.xdst) + $past(yd_step))
    else $error("y loop re-base wrong");
  elem_wait_a: assert property ( // R8
    (step_mid_s and tmode == TM_ELEM) |=> s_r.st == ST_WAIT && !s_r.inx)
    else $error("element mode did not wait");
  xloop_run_a: assert property ( // R9
    (step_mid_s and tmode == TM_XLOOP && s_r.en) |=>
    s_r.st == ST_WAIT ##1 s_r.st == ST_RD)
    else $error("x loop mode paused mid loop");
  byte_lane_a: assert property ( // R11
    (BUS_REQ && BUS_WE && BUS_SIZE == WID_8) |-> $onehot(BUS_BE))
    else $error("byte write on several lanes");
  req_hold_a: assert property ((BUS_REQ && !BUS_ACK) |=>
    BUS_REQ && $stable(BUS_ADDR) && $stable(BUS_WE))
    else $error("bus request dropped before ack");
  done_irq_a: assert property ( // R12
    (s_r.st == ST_STEP && last_x && last_y) |=>
    s_r.stat[ST_DESC] && (IRQ || !s_r.mask[ST_DESC]))
    else $error("no interrupt at descriptor end");
endmodule

/* bench/dmal_mem.sv */
`timescale 1ns/1ps
// ==========================================================
// system bus memory model with adjustable wait states
module dmal_mem (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests from the channel
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic [3:0] lat,
  // answer
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:255];
  logic [3:0] cnt;
  int wr_count;
  // one ack per request after lat idle cycles; read data is junk off ack
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      rdata <= 32'h0;
      wr_count <= 0;
    end else if (ack || !req) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      rdata <= ~rdata;
    end else if (cnt >= lat) begin
      ack <= 1'b1;
      if (we) begin
        for (int i = 0; i < 4; i++) begin
          if (be[i]) mem[addr[9:2]][8*i+:8] <= wdata[8*i+:8];
        end
        wr_count <= wr_count + 1;
      end else begin
        rdata <= mem[addr[9:2]];
      end
    end else begin
      cnt <= cnt + 4'h1;
      rdata <= ~rdata;
    end
  end
endmodule

/* bench/dmal_top_test.sv */
`timescale 1ns/1ps
// ==========================================================
// descriptor loop channel test
module dmal_top_test;
  logic clk = 0, rst_n = 0, trig = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, bd, ba, bw, brd;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, tout, irq;
  logic breq, bwe, back;
  logic [1:0] bresp, rresp, bsz;
  logic [3:0] bbe, lat = 4'h2;
  int err_count = 0, comparisons = 0, tn = 0, t0;
  always #5 clk = ~clk;
  always @(posedge clk) if (tout === 1'b1) tn <= tn + 1;
  dmal_top uut (.CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .TRIG_IN(trig), .TRIG_OUT(tout), .IRQ(irq),
    .BUS_REQ(breq), .BUS_WE(bwe), .BUS_ADDR(ba), .BUS_SIZE(bsz),
    .BUS_WDATA(bw), .BUS_BE(bbe), .BUS_ACK(back), .BUS_RDATA(brd));
  dmal_mem mem_m (.clk(clk), .rst_n(rst_n), .req(breq), .we(bwe),
    .addr(ba), .wdata(bw), .be(bbe), .lat(lat), .ack(back), .rdata(brd));
  // element size on the system bus at every acknowledged access
  always @(posedge clk) begin
    if (breq === 1'b1 && back === 1'b1) begin
      if (bwe) chk(bsz, mem_m.wr_count <= 6 ?
                   dmal_pkg::WID_16 : dmal_pkg::WID_8);
      else chk(bsz, mem_m.wr_count < 6 ?
               dmal_pkg::WID_32 : dmal_pkg::WID_8);
    end
  end
  // ==========================================================
  // checking and closing
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // axi4-lite master tasks, handshakes taken at the rising edge
  task axw(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw;
    logic [1:0] r;
    ta = 0;
    tw = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready === 1'b1 && awv === 1'b1) begin
        ta = 1;
        awv <= 0;
      end
      if (wready === 1'b1 && wv === 1'b1) begin
        tw = 1;
        wv <= 0;
      end
    end while (!(ta && tw));
    do begin
      @(posedge clk);
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
    chk({30'h0, r}, 32'h0);
  endtask
  task axr(input logic [31:0] a, input logic [31:0] e,
           input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
    end while (arready !== 1'b1);
    arv <= 0;
    do begin
      @(posedge clk);
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
    chk({30'h0, r}, {30'h0, er});
    if (er == 2'h0) chk(d, e);
  endtask
  // one trigger pulse, then wait for the given write total
  task pulse_wait(input int n);
    @(posedge clk);
    trig <= 1;
    @(posedge clk);
    trig <= 0;
    for (int i = 0; i < 300 && mem_m.wr_count < n; i++) @(posedge clk);
    chk(mem_m.wr_count, n);
  endtask
  initial begin
    #300000;
    err_count++;
    wrap_up();
  end
  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) mem_m.mem[i] = 32'h0;
    for (int i = 8'h80; i < 8'h88; i++) mem_m.mem[i] = 32'hffffffff;
    mem_m.mem[8'h40] = 32'haaaa1234;
    mem_m.mem[8'h41] = 32'hbbbb5678;
    mem_m.mem[8'hc0] = 32'h44332211;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    axr(dmal_pkg::OFS_MASK, 32'h0, dmal_pkg::RESP_OKAY);
    axr(32'h100, 32'h0, dmal_pkg::RESP_SLVERR);
    // desc0: word to half, src fixed, dst step 2, 2 loops, y src 1
    axw(32'h20, 32'h100);
    axw(32'h24, 32'h200);
    axw(32'h28, 32'h00020003);
    axw(32'h2c, 32'h00020000);
    axw(32'h30, 32'h00080001);
    axw(32'h34, 32'h66);
    // desc1: bytes, src step 1, dst step 3, one X loop per trigger
    axw(32'h40, 32'h300);
    axw(32'h44, 32'h380);
    axw(32'h48, 32'h00010004);
    axw(32'h4c, 32'h00030001);
    axw(32'h50, 32'h0);
    axw(32'h54, 32'h10);
    axw(dmal_pkg::OFS_CTRL, 32'h3);
    pulse_wait(1);
    repeat (30) @(posedge clk);
    chk(mem_m.wr_count, 1);
    chk(tn, 1);
    axr(dmal_pkg::OFS_STAT, 32'h1, dmal_pkg::RESP_OKAY);
    axw(dmal_pkg::OFS_STAT, 32'h1);
    axr(dmal_pkg::OFS_STAT, 32'h0, dmal_pkg::RESP_OKAY);
    for (int k = 2; k <= 6; k++) pulse_wait(k);
    repeat (20) @(posedge clk);
    t0 = tn;
    chk(mem_m.mem[8'h80], 32'hffff1234);
    chk(mem_m.mem[8'h81], 32'hffff1234);
    chk(mem_m.mem[8'h82], 32'hffff1234);
    chk(mem_m.mem[8'h83], 32'hffffffff);
    chk(mem_m.mem[8'h84], 32'hffff5678);
    chk(mem_m.mem[8'h86], 32'hffff5678);
    chk(mem_m.mem[8'h87], 32'hffffffff);
    lat <= 4'h0;
    // software trigger starts the whole X loop of descriptor 1
    axw(dmal_pkg::OFS_CTRL, 32'h7);
    for (int i = 0; i < 300 && mem_m.wr_count < 10; i++) @(posedge clk);
    chk(mem_m.wr_count, 10);
    repeat (20) @(posedge clk);
    chk(mem_m.mem[8'he0], 32'h22000011);
    chk(mem_m.mem[8'he1], 32'h00330000);
    chk(mem_m.mem[8'he2], 32'h00004400);
    chk(tn - t0, 1);
    chk({31'h0, irq}, 32'h0);
    axr(dmal_pkg::OFS_STAT, 32'h3, dmal_pkg::RESP_OKAY);
    axw(dmal_pkg::OFS_MASK, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    axw(dmal_pkg::OFS_STAT, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    axr(dmal_pkg::OFS_STAT, 32'h1, dmal_pkg::RESP_OKAY);
    wrap_up();
  end
endmodule
